// ==== design/dou_top.sv ====
`timescale 1ns/1ps
`include "dou_defs.svh"
module dou_top
(
	input  logic                  clk,
	input  logic                  rst,
	input  logic                  issue_valid,
	input  dou_pkg::dou_instr_t   instr,
	input  dou_pkg::dou_load_t    load,
	input  logic [`DOU_SEL_W-1:0]  peek_sel,
	output logic [`DOU_W-1:0]      peek_data,
	output logic [`DOU_W-1:0]      result,
	output logic [`DOU_SEL_W-1:0]  result_dst,
	output logic                  result_valid,
	output dou_pkg::dou_unit_t    active_unit,
	output dou_pkg::dou_flags_t   flags
);
	logic [`DOU_W-1:0]      regs [`DOU_REG_N];
	logic [`DOU_W-1:0]      next_regs [`DOU_REG_N];
	logic [`DOU_W-1:0]      next_peek_data;
	logic [`DOU_W-1:0]      next_result;
	logic [`DOU_SEL_W-1:0]  next_result_dst;
	logic                  next_result_valid;
	dou_pkg::dou_unit_t    next_active_unit;
	dou_pkg::dou_flags_t   next_flags;

	dou_pkg::dou_unit_t    unit;
	logic                  fire;
	logic [`DOU_W-1:0]      dst_val;
	logic [`DOU_W-1:0]      opa;
	logic [`DOU_W-1:0]      opb_reg;
	logic [`DOU_W-1:0]      opb;
	logic [`DOU_W-1:0]      imm_ext;
	logic [`DOU_W-1:0]      mac_res;
	logic [`DOU_W-1:0]      shift_res;
	logic [`DOU_W-1:0]      alu_res;
	logic [`DOU_W-1:0]      unit_res;
	logic [`DOU_W-1:0]      norm_res;
	logic [`DOU_W-1:0]      div_res;
	logic                  shift_left;
	logic                  shift_arith;
	localparam int         EXT_W = `DOU_E_MSB - `DOU_E_LSB + 1;

	// opcode to unit; mixed products exist only as accumulate forms
	function automatic dou_pkg::dou_unit_t unit_of(input dou_pkg::dou_op_t op);
		case (op)
			dou_pkg::multiply_add_op,
			dou_pkg::multiply_minus_op,
			dou_pkg::signed_unsigned_accum,
			dou_pkg::unsigned_pair_accum,
			dou_pkg::halved_accum_multiply,
			dou_pkg::word_shifted_accum_multiply,
			dou_pkg::plain_multiply:        unit_of = dou_pkg::unit_mac;
			dou_pkg::arith_right_shift,
			dou_pkg::imm_arith_right_shift,
			dou_pkg::logic_right_shift,
			dou_pkg::imm_logic_right_shift,
			dou_pkg::logic_left_shift,
			dou_pkg::imm_logic_left_shift:  unit_of = dou_pkg::unit_shift;
			dou_pkg::add_op,
			dou_pkg::immediate_sum_op,
			dou_pkg::sub_op,
			dou_pkg::immediate_difference_op,
			dou_pkg::less_than_compare,
			dou_pkg::zeroing_op,
			dou_pkg::plus_one_op,
			dou_pkg::minus_one_op,
			dou_pkg::magnitude_op,
			dou_pkg::twos_complement_op,
			dou_pkg::clip_op,
			dou_pkg::rounding_op,
			dou_pkg::leading_bit_count_op,
			dou_pkg::register_copy_op,
			dou_pkg::accumulate_add_op,
			dou_pkg::accumulate_minus_op,
			dou_pkg::division_step_op,
			dou_pkg::and_op,
			dou_pkg::immediate_conjunction_op,
			dou_pkg::or_op,
			dou_pkg::immediate_disjunction_op,
			dou_pkg::xor_op,
			dou_pkg::immediate_exclusive_disjunction_op,
			dou_pkg::invert_op:             unit_of = dou_pkg::unit_alu;
			// nop and stray codes of the 6-bit field never write the file
			default:                        unit_of = dou_pkg::unit_none;
		endcase
	endfunction

	// less-than has no immediate form by construction
	function automatic logic takes_imm(input dou_pkg::dou_op_t op);
		case (op)
			dou_pkg::immediate_sum_op,
			dou_pkg::immediate_difference_op,
			dou_pkg::immediate_conjunction_op,
			dou_pkg::immediate_disjunction_op,
			dou_pkg::immediate_exclusive_disjunction_op,
			dou_pkg::imm_arith_right_shift,
			dou_pkg::imm_logic_right_shift,
			dou_pkg::imm_logic_left_shift:  takes_imm = 1'b1;
			default:                        takes_imm = 1'b0;
		endcase
	endfunction

	// decoding is one-hot by unit, so two units never write together
	assign unit = unit_of(instr.op);
	assign fire = issue_valid && (unit != dou_pkg::unit_none);

	// every operand port reads the file independently
	assign dst_val = regs[instr.dst];
	assign opa = regs[instr.src_a];
	assign opb_reg = regs[instr.src_b];
	assign imm_ext = {{`DOU_FILL_W{1'b0}}, instr.imm};
	assign opb = takes_imm(instr.op) ? imm_ext : opb_reg;

	assign shift_left = (instr.op == dou_pkg::logic_left_shift) ||
		(instr.op == dou_pkg::imm_logic_left_shift);
	assign shift_arith = (instr.op == dou_pkg::arith_right_shift) ||
		(instr.op == dou_pkg::imm_arith_right_shift);

	// multiplier always reads register b; immediates never feed it
	dou_mac u_mac
	(
		.op     (instr.op),
		.acc    (dst_val),
		.src_a  (opa),
		.src_b  (opb_reg),
		.result (mac_res)
	);

	// amount bits 39..6 are dropped at the port
	dou_shifter
	#(
		.W  (`DOU_W),
		.AW (`DOU_AMT_W)
	)
	u_shifter
	(
		.value  (opa),
		.amount (opb[`DOU_AMT_MSB:0]),
		.left   (shift_left),
		.arith  (shift_arith),
		.result (shift_res)
	);

	// redundant sign bits, the normalising distance
	always_comb
	begin
		logic found;
		found = 1'b0;
		norm_res = `DOU_ZERO;
		for (int k = `DOU_W - 2; k >= 0; k--)
		begin
			if (!found && (opa[k] == opa[`DOU_W-1]))
			begin
				norm_res = norm_res + `DOU_ONE;
			end
			else
			begin
				found = 1'b1;
			end
		end
	end

	// one restoring step: divisor in high part, quotient into lsb
	always_comb
	begin
		logic [`DOU_W-1:0] shifted;
		logic [`DOU_W-1:0] divisor;
		logic [`DOU_W-1:0] trial;
		shifted = {dst_val[`DOU_W-2:0], 1'b0};
		divisor = {{(`DOU_W-`DOU_H_MSB-1){1'b0}}, opa[`DOU_H_MSB:`DOU_H_LSB], {`DOU_H_LSB{1'b0}}};
		trial = shifted - divisor;
		div_res = trial[`DOU_W-1] ? shifted : (trial | `DOU_ONE);
	end

	// register parts: low 15..0, high 31..16, extension 39..32
	always_comb
	begin
		case (instr.op)
			dou_pkg::add_op,
			dou_pkg::immediate_sum_op:         alu_res = opa + opb;
			dou_pkg::sub_op,
			dou_pkg::immediate_difference_op:  alu_res = opa - opb;
			// compare is signed over all 40 bits
			dou_pkg::less_than_compare:        alu_res = ($signed(opa) < $signed(opb)) ? `DOU_ONE : `DOU_ZERO;
			dou_pkg::zeroing_op:               alu_res = `DOU_ZERO;
			dou_pkg::plus_one_op:              alu_res = opa + `DOU_ONE;
			dou_pkg::minus_one_op:             alu_res = opa - `DOU_ONE;
			dou_pkg::magnitude_op:             alu_res = opa[`DOU_W-1] ? -opa : opa;
			dou_pkg::twos_complement_op:       alu_res = -opa;
			// clip saturates to the 32-bit fixed-point range
			dou_pkg::clip_op:
			begin
				if ($signed(opa) > $signed(`DOU_CLIP_MAX))
					alu_res = `DOU_CLIP_MAX;
				else if ($signed(opa) < $signed(`DOU_CLIP_MIN))
					alu_res = `DOU_CLIP_MIN;
				else
					alu_res = opa;
			end
			// rounds into the high part, low part cleared
			dou_pkg::rounding_op:              alu_res = (opa + `DOU_RND_BIAS) & `DOU_RND_MASK;
			dou_pkg::leading_bit_count_op:     alu_res = norm_res;
			dou_pkg::register_copy_op:         alu_res = opa;
			dou_pkg::accumulate_add_op:        alu_res = dst_val + opa;
			dou_pkg::accumulate_minus_op:      alu_res = dst_val - opa;
			dou_pkg::division_step_op:         alu_res = div_res;
			dou_pkg::and_op,
			dou_pkg::immediate_conjunction_op: alu_res = opa & opb;
			dou_pkg::or_op,
			dou_pkg::immediate_disjunction_op: alu_res = opa | opb;
			dou_pkg::xor_op,
			dou_pkg::immediate_exclusive_disjunction_op: alu_res = opa ^ opb;
			dou_pkg::invert_op:                alu_res = ~opa;
			default:                           alu_res = `DOU_ZERO;
		endcase
	end

	// full 40-bit result from exactly one unit
	always_comb
	begin
		case (unit)
			dou_pkg::unit_mac:   unit_res = mac_res;
			dou_pkg::unit_alu:   unit_res = alu_res;
			dou_pkg::unit_shift: unit_res = shift_res;
			default:             unit_res = `DOU_ZERO;
		endcase
	end

	// file writes; instruction beats a same-cycle load to one register
	always_comb
	begin
		for (int r = 0; r < `DOU_REG_N; r++)
		begin
			next_regs[r] = regs[r];
		end
		if (load.en)
		begin
			next_regs[load.sel] = load.data;
		end
		if (fire)
		begin
			next_regs[instr.dst] = unit_res;
		end
	end

	// result port and status track the last instruction only
	always_comb
	begin
		next_result = result;
		next_result_dst = result_dst;
		next_result_valid = fire;
		next_active_unit = issue_valid ? unit : dou_pkg::unit_none;
		next_flags = flags;
		next_peek_data = regs[peek_sel];
		if (fire)
		begin
			next_result = unit_res;
			next_result_dst = instr.dst;
			next_flags.zero = (unit_res == `DOU_ZERO);
			next_flags.neg = unit_res[`DOU_W-1];
			// extension not a copy of bit 31 means 32-bit overflow
			next_flags.ovf32 = (unit_res[`DOU_E_MSB:`DOU_E_LSB] != {EXT_W{unit_res[`DOU_H_MSB]}});
		end
	end

	// all eight entries clear on reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int r = 0; r < `DOU_REG_N; r++)
			begin
				regs[r] <= `DOU_GPR_RST;
			end
		end
		else
		begin
			regs <= next_regs;
		end
	end

	// outputs come straight from flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			result <= `DOU_ZERO;
			result_dst <= '0;
			result_valid <= 1'b0;
			active_unit <= dou_pkg::unit_none;
			flags <= '0;
			peek_data <= `DOU_ZERO;
		end
		else
		begin
			result <= next_result;
			result_dst <= next_result_dst;
			result_valid <= next_result_valid;
			active_unit <= next_active_unit;
			flags <= next_flags;
			peek_data <= next_peek_data;
		end
	end
endmodule

// ==== design/dou_defs.svh ====
`ifndef DOU_DEFS_SVH
`define DOU_DEFS_SVH
`define DOU_W 40
`define DOU_REG_N 8
`define DOU_SEL_W 3
`define DOU_L_LSB 0
`define DOU_L_MSB 15
`define DOU_H_LSB 16
`define DOU_H_MSB 31
`define DOU_E_LSB 32
`define DOU_E_MSB 39
`define DOU_PART_W 16
`define DOU_FILL_W 24
`define DOU_AMT_W 6
`define DOU_AMT_MSB 5
`define DOU_SS_ALIGN 1
`define DOU_HALVE_SH 1
`define DOU_WORD_SH 16
`define DOU_GPR_RST 40'h00_0000_0000
`define DOU_ZERO 40'h00_0000_0000
`define DOU_ONE 40'h00_0000_0001
`define DOU_RND_BIAS 40'h00_0000_8000
`define DOU_RND_MASK 40'hff_ffff_0000
`define DOU_CLIP_MAX 40'h00_7fff_ffff
`define DOU_CLIP_MIN 40'hff_8000_0000
`endif

// ==== design/dou_pkg.sv ====
package dou_pkg;
`include "dou_defs.svh"
	typedef enum logic [5:0]
	{
		nop_op,
		multiply_add_op, multiply_minus_op, signed_unsigned_accum, unsigned_pair_accum,
		halved_accum_multiply, word_shifted_accum_multiply, plain_multiply,
		add_op, immediate_sum_op, sub_op, immediate_difference_op, less_than_compare,
		zeroing_op, plus_one_op, minus_one_op, magnitude_op, twos_complement_op,
		clip_op, rounding_op, leading_bit_count_op, register_copy_op,
		accumulate_add_op, accumulate_minus_op, division_step_op,
		and_op, immediate_conjunction_op, or_op, immediate_disjunction_op,
		xor_op, immediate_exclusive_disjunction_op, invert_op,
		arith_right_shift, imm_arith_right_shift, logic_right_shift,
		imm_logic_right_shift, logic_left_shift, imm_logic_left_shift
	} dou_op_t;

	typedef enum logic [1:0]
	{
		unit_none, unit_mac, unit_alu, unit_shift
	} dou_unit_t;

	typedef struct packed
	{
		dou_op_t               op;
		logic [`DOU_SEL_W-1:0]  dst;
		logic [`DOU_SEL_W-1:0]  src_a;
		logic [`DOU_SEL_W-1:0]  src_b;
		logic [`DOU_PART_W-1:0] imm;
	} dou_instr_t;

	typedef struct packed
	{
		logic                  en;
		logic [`DOU_SEL_W-1:0] sel;
		logic [`DOU_W-1:0]     data;
	} dou_load_t;

	typedef struct packed
	{
		logic zero;
		logic neg;
		logic ovf32;
	} dou_flags_t;
endpackage

// ==== design/dou_mac.sv ====
`timescale 1ns/1ps
`include "dou_defs.svh"
module dou_mac
(
	input  dou_pkg::dou_op_t   op,
	input  logic [`DOU_W-1:0]   acc,
	input  logic [`DOU_W-1:0]   src_a,
	input  logic [`DOU_W-1:0]   src_b,
	output logic [`DOU_W-1:0]   result
);
	logic signed [`DOU_PART_W-1:0] a_hi;
	logic signed [`DOU_PART_W-1:0] b_hi;
	logic        [`DOU_PART_W-1:0] a_lo;
	logic        [`DOU_PART_W-1:0] b_lo;
	logic signed [31:0]            p_ss;
	logic signed [32:0]            p_su;
	logic        [31:0]            p_uu;
	logic signed [`DOU_W-1:0]      prod_ss;
	logic signed [`DOU_W-1:0]      prod_su;
	logic        [`DOU_W-1:0]      prod_uu;
	logic signed [`DOU_W-1:0]      acc_s;

	// high parts carry the sign in bit 31
	assign a_hi = src_a[`DOU_H_MSB:`DOU_H_LSB];
	assign b_hi = src_b[`DOU_H_MSB:`DOU_H_LSB];
	assign a_lo = src_a[`DOU_L_MSB:`DOU_L_LSB];
	assign b_lo = src_b[`DOU_L_MSB:`DOU_L_LSB];
	assign acc_s = acc;

	assign p_ss = a_hi * b_hi;
	assign p_su = a_hi * $signed({1'b0, b_lo});
	assign p_uu = a_lo * b_lo;

	// fractional product realigned so its point sits at 31/30
	assign prod_ss = `DOU_W'(p_ss) <<< `DOU_SS_ALIGN;
	assign prod_su = `DOU_W'(p_su);
	assign prod_uu = `DOU_W'(p_uu);

	always_comb
	begin
		case (op)
			dou_pkg::multiply_add_op:             result = acc + prod_ss;
			dou_pkg::multiply_minus_op:           result = acc - prod_ss;
			dou_pkg::signed_unsigned_accum:       result = acc + prod_su;
			dou_pkg::unsigned_pair_accum:         result = acc + prod_uu;
			// input shifter keeps the sign of the accumulator
			dou_pkg::halved_accum_multiply:       result = (acc_s >>> `DOU_HALVE_SH) + prod_ss;
			dou_pkg::word_shifted_accum_multiply: result = (acc_s >>> `DOU_WORD_SH) + prod_ss;
			dou_pkg::plain_multiply:              result = prod_ss;
			default:                              result = `DOU_ZERO;
		endcase
	end
endmodule

// ==== design/dou_shifter.sv ====
`timescale 1ns/1ps
module dou_shifter
#(
	parameter int W  = 40,
	parameter int AW = 6
)
(
	input  logic [W-1:0]  value,
	input  logic [AW-1:0] amount,
	input  logic          left,
	input  logic          arith,
	output logic [W-1:0]  result
);
	logic [AW:0][W-1:0] stage;
	logic               fill;

	// only bit 39 is replicated, and only for the arithmetic kind
	assign fill = arith & value[W-1];
	assign stage[0] = value;

	// log-depth stages: whole shift settles in one cycle
	genvar i;
	generate
		for (i = 0; i < AW; i++)
		begin : g_stage
			localparam int S = 1 << i;
			assign stage[i+1] = !amount[i] ? stage[i] :
				left ? {stage[i][W-1-S:0], {S{1'b0}}} :
				{{S{fill}}, stage[i][W-1:S]};
		end
	endgenerate

	// amounts past 39 fall out naturally as full fill
	assign result = stage[AW];
endmodule

// ==== bench/dou_asserts.sv ====
`timescale 1ns/1ps
module dou_asserts
(
	input logic                clk,
	input logic                rst,
	input logic                issue_valid,
	input dou_pkg::dou_instr_t instr,
	input dou_pkg::dou_load_t  load,
	input logic [2:0]          peek_sel,
	input logic [39:0]         peek_data,
	input logic [39:0]         result,
	input logic [2:0]          result_dst,
	input logic                result_valid,
	input dou_pkg::dou_unit_t  active_unit,
	input dou_pkg::dou_flags_t flags
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_taken;
		issue_valid && instr.op inside {[dou_pkg::multiply_add_op:dou_pkg::imm_logic_left_shift]};
	endsequence
	sequence s_answer;
		result_valid && result_dst == $past(instr.dst);
	endsequence
	a_answer_next: assert property (s_taken |=> s_answer)
		else $error("no answer one cycle after issue");
	a_idle_quiet: assert property (!(issue_valid
		&& instr.op inside {[dou_pkg::multiply_add_op:dou_pkg::imm_logic_left_shift]})
		|=> !result_valid && active_unit == dou_pkg::unit_none) else $error("activity without issue");
	a_unit_mac: assert property (s_taken ##0 instr.op inside {[dou_pkg::multiply_add_op:dou_pkg::plain_multiply]}
		|=> active_unit == dou_pkg::unit_mac) else $error("multiply not on mac");
	a_unit_alu: assert property (s_taken ##0 instr.op inside {[dou_pkg::add_op:dou_pkg::invert_op]}
		|=> active_unit == dou_pkg::unit_alu) else $error("alu op on wrong unit");
	a_unit_shift: assert property (s_taken ##0 instr.op inside {[dou_pkg::arith_right_shift:dou_pkg::imm_logic_left_shift]}
		|=> active_unit == dou_pkg::unit_shift) else $error("shift not on shifter");
	a_imm_fill: assert property (issue_valid && instr.op == dou_pkg::immediate_conjunction_op
		|=> result[39:16] == 24'h00_0000) else $error("immediate not zero filled");
	a_shift_fill: assert property (issue_valid && instr.op == dou_pkg::imm_logic_left_shift && instr.imm[5:0] == 6'h20
		|=> result[31:0] == 32'h0000_0000) else $error("shift amount misread");
	// reset clears result, so the first cycle after it is skipped
	a_result_hold: assert property (!result_valid && !$past(rst) |-> $stable(result) && $stable(flags))
		else $error("result changed without instruction");
	a_flag_track: assert property (result_valid |-> flags.zero == (result == 40'h00_0000_0000)
		&& flags.ovf32 == (result[39:32] != {8{result[31]}})) else $error("flags disagree with result");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                issue_valid = 1'b0;
	dou_pkg::dou_instr_t instr = '0;
	dou_pkg::dou_load_t  load = '0;
	logic [2:0]          peek_sel = 3'h0;
	logic [39:0]         peek_data, result;
	logic [2:0]          result_dst;
	logic                result_valid;
	dou_pkg::dou_unit_t  active_unit;
	dou_pkg::dou_flags_t flags;
	logic [39:0]         g [8];
	int                  error_cnt = 0;
	int                  n_tests = 0;
	always #4 clk = ~clk;
	dou_top i_dou_top (.clk(clk), .rst(rst), .issue_valid(issue_valid), .instr(instr), .load(load),
		.peek_sel(peek_sel), .peek_data(peek_data), .result(result), .result_dst(result_dst),
		.result_valid(result_valid), .active_unit(active_unit), .flags(flags));
	task finish_test;
		$display("errors=%0d checks=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task check(input logic [39:0] seen, input logic [39:0] want);
		n_tests++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask
	// low product bits do not depend on signedness, so extension alone sets the sign
	function automatic logic [39:0] ss(input logic [39:0] a, input logic [39:0] b);
		return ({{24{a[31]}}, a[31:16]} * {{24{b[31]}}, b[31:16]}) << 1;
	endfunction
	function automatic logic [39:0] su(input logic [39:0] a, input logic [39:0] b);
		return {{24{a[31]}}, a[31:16]} * {24'h00_0000, b[15:0]};
	endfunction
	function automatic logic [39:0] uu(input logic [39:0] a, input logic [39:0] b);
		return {24'h00_0000, a[15:0]} * {24'h00_0000, b[15:0]};
	endfunction
	function automatic logic [39:0] asr(input logic [39:0] v, input int n);
		return $signed(v) >>> n;
	endfunction
	task run(input dou_pkg::dou_op_t op, input logic [2:0] d, a, b, input logic [15:0] imm,
		input logic [39:0] want, input dou_pkg::dou_unit_t u);
		@(posedge clk);
		issue_valid <= 1'b1;
		instr <= '{op, d, a, b, imm};
		@(posedge clk);
		issue_valid <= 1'b0;
		#1;
		check(result, want);
		check(result_dst, d);
		check(result_valid, 1'b1);
		check(active_unit, u);
		check(flags, {want == 40'h0, want[39], want[39:32] != {8{want[31]}}});
		g[d] = want;
	endtask
	task load_reg(input logic [2:0] r, input logic [39:0] d);
		@(posedge clk);
		load <= '{1'b1, r, d};
		@(posedge clk);
		load <= '0;
		g[r] = d;
	endtask
	task t_reset;
		@(posedge clk);
		#1;
		check(result, 40'h0);
		check(result_valid, 1'b0);
		check(active_unit, dou_pkg::unit_none);
		check(peek_data, 40'h0);
	endtask
	task t_parts;
		load_reg(0, 40'h00_6000_0003);
		load_reg(1, 40'hff_a000_8001);
		load_reg(2, 40'h12_3456_789a);
		load_reg(3, 40'h00_0001_0000);
		load_reg(4, 40'hff_8000_ffff);
		load_reg(5, 40'h00_0000_ffe7);
		load_reg(6, 40'h80_0000_0001);
		load_reg(7, 40'h7f_ffff_ffff);
		peek_sel <= 3'h1;
		repeat (2) @(posedge clk);
		#1;
		check(peek_data, 40'hff_a000_8001);
	endtask
	task t_mac;
		run(dou_pkg::multiply_add_op, 2, 0, 1, 0, g[2] + ss(g[0], g[1]), dou_pkg::unit_mac);
		run(dou_pkg::multiply_minus_op, 2, 0, 1, 0, g[2] - ss(g[0], g[1]), dou_pkg::unit_mac);
		run(dou_pkg::signed_unsigned_accum, 3, 1, 4, 0, g[3] + su(g[1], g[4]), dou_pkg::unit_mac);
		run(dou_pkg::unsigned_pair_accum, 3, 4, 1, 0, g[3] + uu(g[4], g[1]), dou_pkg::unit_mac);
		run(dou_pkg::halved_accum_multiply, 6, 1, 1, 0, asr(g[6], 1) + ss(g[1], g[1]), dou_pkg::unit_mac);
		run(dou_pkg::word_shifted_accum_multiply, 6, 0, 1, 0, asr(g[6], 16) + ss(g[0], g[1]), dou_pkg::unit_mac);
		run(dou_pkg::plain_multiply, 7, 4, 4, 0, ss(g[4], g[4]), dou_pkg::unit_mac);
		run(dou_pkg::multiply_add_op, 0, 0, 0, 0, g[0] + ss(g[0], g[0]), dou_pkg::unit_mac);
	endtask
	task t_alu;
		run(dou_pkg::add_op, 0, 2, 3, 0, g[2] + g[3], dou_pkg::unit_alu);
		run(dou_pkg::sub_op, 1, 2, 3, 0, g[2] - g[3], dou_pkg::unit_alu);
		run(dou_pkg::immediate_sum_op, 2, 6, 0, 16'hffff, g[6] + 40'hffff, dou_pkg::unit_alu);
		run(dou_pkg::immediate_difference_op, 3, 7, 0, 16'h8000, g[7] - 40'h8000, dou_pkg::unit_alu);
		run(dou_pkg::less_than_compare, 4, 6, 2, 0, {39'h0, $signed(g[6]) < $signed(g[2])}, dou_pkg::unit_alu);
		run(dou_pkg::and_op, 5, 2, 7, 0, g[2] & g[7], dou_pkg::unit_alu);
		run(dou_pkg::or_op, 6, 2, 1, 0, g[2] | g[1], dou_pkg::unit_alu);
		run(dou_pkg::xor_op, 7, 2, 2, 0, 40'h0, dou_pkg::unit_alu);
		run(dou_pkg::immediate_conjunction_op, 0, 6, 0, 16'ha5c3, g[6] & 40'ha5c3, dou_pkg::unit_alu);
		run(dou_pkg::immediate_disjunction_op, 1, 6, 0, 16'ha5c3, g[6] | 40'ha5c3, dou_pkg::unit_alu);
		run(dou_pkg::immediate_exclusive_disjunction_op, 2, 6, 0, 16'hffff, g[6] ^ 40'hffff, dou_pkg::unit_alu);
		run(dou_pkg::invert_op, 3, 6, 0, 0, ~g[6], dou_pkg::unit_alu);
		run(dou_pkg::zeroing_op, 4, 6, 0, 0, 40'h0, dou_pkg::unit_alu);
		run(dou_pkg::plus_one_op, 5, 3, 0, 0, g[3] + 40'h1, dou_pkg::unit_alu);
		run(dou_pkg::minus_one_op, 6, 4, 0, 0, 40'hff_ffff_ffff, dou_pkg::unit_alu);
		run(dou_pkg::twos_complement_op, 7, 1, 0, 0, -g[1], dou_pkg::unit_alu);
		run(dou_pkg::magnitude_op, 0, 6, 0, 0, 40'h1, dou_pkg::unit_alu);
		run(dou_pkg::register_copy_op, 1, 2, 0, 0, g[2], dou_pkg::unit_alu);
		run(dou_pkg::accumulate_add_op, 2, 5, 0, 0, g[2] + g[5], dou_pkg::unit_alu);
		run(dou_pkg::accumulate_minus_op, 3, 5, 0, 0, g[3] - g[5], dou_pkg::unit_alu);
		run(dou_pkg::rounding_op, 4, 2, 0, 0, (g[2] + 40'h8000) & 40'hff_ffff_0000, dou_pkg::unit_alu);
	endtask
	task t_shift;
		load_reg(1, 40'hff_a000_8001);
		load_reg(5, 40'h00_0000_ffe7);
		run(dou_pkg::arith_right_shift, 2, 1, 5, 0, asr(g[1], 39), dou_pkg::unit_shift);
		run(dou_pkg::logic_right_shift, 3, 1, 5, 0, g[1] >> 39, dou_pkg::unit_shift);
		run(dou_pkg::logic_left_shift, 4, 1, 5, 0, g[1] << 39, dou_pkg::unit_shift);
		run(dou_pkg::imm_arith_right_shift, 0, 1, 0, 16'hffc4, asr(g[1], 4), dou_pkg::unit_shift);
		run(dou_pkg::imm_logic_right_shift, 6, 1, 0, 16'h0010, g[1] >> 16, dou_pkg::unit_shift);
		run(dou_pkg::imm_logic_left_shift, 7, 1, 0, 16'hffe0, g[1] << 32, dou_pkg::unit_shift);
	endtask
	task t_nop;
		@(posedge clk);
		issue_valid <= 1'b1;
		instr.op <= dou_pkg::nop_op;
		@(posedge clk);
		issue_valid <= 1'b0;
		#1;
		check(result_valid, 1'b0);
		check(active_unit, dou_pkg::unit_none);
		check(result, g[7]);
	endtask
	task t_misc;
		load_reg(0, 40'h01_2345_6789);
		load_reg(1, 40'hfe_0000_0000);
		load_reg(2, 40'h00_1234_5678);
		load_reg(3, 40'h00_0003_0000);
		load_reg(4, 40'h00_0002_0000);
		load_reg(5, 40'h00_0000_8000);
		run(dou_pkg::clip_op, 0, 0, 0, 0, 40'h00_7fff_ffff, dou_pkg::unit_alu);
		run(dou_pkg::clip_op, 1, 1, 0, 0, 40'hff_8000_0000, dou_pkg::unit_alu);
		run(dou_pkg::clip_op, 2, 2, 0, 0, 40'h00_1234_5678, dou_pkg::unit_alu);
		run(dou_pkg::leading_bit_count_op, 6, 2, 0, 0, 40'h00_0000_000a, dou_pkg::unit_alu);
		run(dou_pkg::leading_bit_count_op, 7, 1, 0, 0, 40'h00_0000_0008, dou_pkg::unit_alu);
		run(dou_pkg::division_step_op, 3, 4, 0, 0, 40'h00_0004_0001, dou_pkg::unit_alu);
		run(dou_pkg::division_step_op, 5, 4, 0, 0, 40'h00_0001_0000, dou_pkg::unit_alu);
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_parts;
		t_mac;
		t_alu;
		t_shift;
		t_nop;
		t_misc;
		finish_test;
	end
	initial
	begin
		#200000;
		error_cnt++;
		finish_test;
	end
endmodule
bind dou_top dou_asserts i_dou_asserts (.clk(clk), .rst(rst), .issue_valid(issue_valid), .instr(instr),
	.load(load), .peek_sel(peek_sel), .peek_data(peek_data), .result(result), .result_dst(result_dst),
	.result_valid(result_valid), .active_unit(active_unit), .flags(flags));
